// File: rtl/output_group.sv
`timescale 1ns/1ps
`default_nettype none

// one driver element: eight outputs sharing an overheat sense, each with its own hold
module output_group #(
    parameter int unsigned WIDTH     = port_alarm_pkg::GROUP_WIDTH,
    parameter int unsigned RETRY_CYC = port_alarm_pkg::RETRY_CYC
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             nrst_i,
    input  wire logic             ce_i,
    // command and sense, already synchronised
    input  wire logic [WIDTH-1:0] cmd_i,
    input  wire logic [WIDTH-1:0] ovc_i,
    input  wire logic             hot_i,
    input  wire logic             cool_i,
    // drive and status
    output logic      [WIDTH-1:0] drive_o,
    output logic                  latched_o
);

    ////////////////////////////////////////////////////////////////////////////
    localparam int unsigned CW = $clog2(RETRY_CYC + 1);

    logic [WIDTH-1:0] cut_r;          // per-output overcurrent cutoff
    logic [WIDTH-1:0] held_r;         // per-output overheat hold
    logic [CW-1:0]    cnt_r [WIDTH];  // retry timers

    // per-output cutoff and retry: a standing short keeps cycling
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cut_r <= '0;
            for (int i = 0; i < WIDTH; i++) cnt_r[i] <= '0;
        end else if (ce_i) begin
            for (int i = 0; i < WIDTH; i++) begin
                if (drive_o[i] && ovc_i[i]) begin
                    cut_r[i] <= 1'b1;
                    cnt_r[i] <= CW'(RETRY_CYC);
                end else if (cut_r[i]) begin
                    if (cnt_r[i] > CW'(1)) cnt_r[i] <= cnt_r[i] - CW'(1);
                    else cut_r[i] <= 1'b0;
                end
            end
        end
    end

    // overheat holds all eight; each releases on cool plus off command
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            held_r <= '0;
        end else if (ce_i) begin
            for (int i = 0; i < WIDTH; i++) begin
                if (hot_i) held_r[i] <= 1'b1;
                else if (cool_i && !cmd_i[i]) held_r[i] <= 1'b0;
            end
        end
    end

    // drive follows command unless cut, held or hot
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) drive_o <= '0;
        else if (ce_i) drive_o <= cmd_i & ~cut_r & ~held_r & {WIDTH{~hot_i}};
    end

    assign latched_o = |held_r;

endmodule : output_group

`default_nettype wire

// File: rtl/port_alarm_pkg.sv
package port_alarm_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // geometry
    localparam int unsigned GROUP_WIDTH   = 8;   // outputs per driver element
    localparam int unsigned GROUP_COUNT   = 8;   // driver elements on the port
    localparam int unsigned PORT_WIDTH    = GROUP_WIDTH * GROUP_COUNT;

    ////////////////////////////////////////////////////////////////////////////
    // alarm code layout
    localparam logic [7:0]  CODE0_FIXED   = 8'h03;  // bits 0 and 1 set
    localparam logic [7:0]  CODE1_FIXED   = 8'h40;  // bit 6 set
    localparam int unsigned CODE1_GRP_LSB = 0;      // group field low bit
    localparam int unsigned CODE1_GRP_W   = 5;      // group field width

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0]  LATCH_RST     = 8'h00;
    localparam logic [63:0] PORT_RST      = 64'h0000_0000_0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // timing: least off time after an overcurrent cutoff before retry
    localparam int unsigned CLK_MHZ       = 200;
    localparam int unsigned RETRY_NS      = 1000;
    localparam int unsigned RETRY_CYC     = (RETRY_NS * CLK_MHZ + 999) / 1000;

    // report state machine
    typedef enum logic [1:0] {
        RPT_IDLE  = 2'b00,
        RPT_SEND  = 2'b01,
        RPT_HOLD  = 2'b10
    } rpt_state_t;

    // alarm code carried to the host link
    typedef struct packed {
        logic [7:0] code1;
        logic [7:0] code0;
    } alarm_code_t;

endpackage : port_alarm_pkg

// File: rtl/protected_output_port_alarm.sv
`timescale 1ns/1ps
`default_nettype none

module protected_output_port_alarm #(
    parameter int unsigned GROUPS    = port_alarm_pkg::GROUP_COUNT,
    parameter int unsigned WIDTH     = port_alarm_pkg::GROUP_WIDTH,
    parameter int unsigned RETRY_CYC = port_alarm_pkg::RETRY_CYC
) (
    // clock, reset, enable
    input  wire logic                      clk_i,
    input  wire logic                      nrst_i,
    input  wire logic                      ce_i,
    // commanded output values from the host link
    input  wire logic [GROUPS*WIDTH-1:0]   cmd_i,
    // load-side sense pins, asynchronous
    input  wire logic [GROUPS*WIDTH-1:0]   ovc_i,
    input  wire logic [GROUPS-1:0]         hot_i,
    input  wire logic [GROUPS-1:0]         cool_i,
    input  wire logic                      alarm_report_jumper_i,
    // host report handshake
    input  wire logic                      report_ack_i,
    output logic                           report_valid_o,
    output port_alarm_pkg::alarm_code_t    report_code_o,
    output logic                           link_suspend_o,
    // load drive and lamps
    output logic [GROUPS*WIDTH-1:0]        drive_o,
    output logic [GROUPS-1:0]              fault_lamp_o,
    output logic                           alarm_lamp_o
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers, two flops each
    logic [GROUPS*WIDTH-1:0] ovc_s1_r, ovc_s2_r;
    logic [GROUPS-1:0]       hot_s1_r, hot_s2_r, cool_s1_r, cool_s2_r;
    logic                    jmp_s1_r, jmp_s2_r;

    // sense pins cross from the load side
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ovc_s1_r  <= '0;
            ovc_s2_r  <= '0;
            hot_s1_r  <= '0;
            hot_s2_r  <= '0;
            cool_s1_r <= '0;
            cool_s2_r <= '0;
            jmp_s1_r  <= 1'b0;
            jmp_s2_r  <= 1'b0;
        end else if (ce_i) begin
            ovc_s1_r  <= ovc_i;
            ovc_s2_r  <= ovc_s1_r;
            hot_s1_r  <= hot_i;
            hot_s2_r  <= hot_s1_r;
            cool_s1_r <= cool_i;
            cool_s2_r <= cool_s1_r;
            jmp_s1_r  <= alarm_report_jumper_i;
            jmp_s2_r  <= jmp_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // one element per group
    logic [GROUPS-1:0] latched;

    for (genvar g = 0; g < GROUPS; g++) begin : g_grp
        output_group #(
            .WIDTH     (WIDTH),
            .RETRY_CYC (RETRY_CYC)
        ) u_grp (
            .clk_i     (clk_i),
            .nrst_i    (nrst_i),
            .ce_i      (ce_i),
            .cmd_i     (cmd_i[g*WIDTH +: WIDTH]),
            .ovc_i     (ovc_s2_r[g*WIDTH +: WIDTH]),
            .hot_i     (hot_s2_r[g]),
            .cool_i    (cool_s2_r[g]),
            .drive_o   (drive_o[g*WIDTH +: WIDTH]),
            .latched_o (latched[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // fault lamps, from flops so they never glitch
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) fault_lamp_o <= '0;
        else if (ce_i) fault_lamp_o <= latched;
    end

    ////////////////////////////////////////////////////////////////////////////
    // lowest latched group, encoded as group plus one
    function automatic logic [4:0] first_group(input logic [GROUPS-1:0] v);
        first_group = 5'h00;
        for (int i = GROUPS - 1; i >= 0; i--) begin
            if (v[i]) first_group = 5'(i + 1);
        end
    endfunction : first_group

    port_alarm_pkg::rpt_state_t state_r;
    logic                       enabled;

    // shorted jumper (high) means report; the printed body text disagrees
    assign enabled = jmp_s2_r;

    // report sequence: send code, wait for ack, hold alarm until clear
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_r       <= port_alarm_pkg::RPT_IDLE;
            report_code_o <= '0;
        end else if (ce_i) begin
            unique case (state_r)
                port_alarm_pkg::RPT_IDLE: begin
                    if (enabled && |latched) begin
                        state_r             <= port_alarm_pkg::RPT_SEND;
                        report_code_o.code0 <= port_alarm_pkg::CODE0_FIXED;
                        report_code_o.code1 <= port_alarm_pkg::CODE1_FIXED
                                             | {3'b000, first_group(latched)};
                    end
                end
                port_alarm_pkg::RPT_SEND: begin
                    if (report_ack_i) state_r <= port_alarm_pkg::RPT_HOLD;
                end
                port_alarm_pkg::RPT_HOLD: begin
                    // alarm state lasts until every latch is released
                    if (!(|latched)) state_r <= port_alarm_pkg::RPT_IDLE;
                end
                default: state_r <= port_alarm_pkg::RPT_IDLE;
            endcase
        end
    end

    // handshake and lamp decode
    assign report_valid_o = (state_r == port_alarm_pkg::RPT_SEND);
    assign link_suspend_o = (state_r != port_alarm_pkg::RPT_IDLE);
    assign alarm_lamp_o   = link_suspend_o;

endmodule : protected_output_port_alarm

`default_nettype wire

// File: sim/port_alarm_sva.sv
`timescale 1ns/1ps
`default_nettype none
// watches only the pins of the port block
module port_alarm_sva #(
    parameter int unsigned GROUPS    = 8,
    parameter int unsigned WIDTH     = 8,
    parameter int unsigned RETRY_CYC = 4
) (
    // clock and controls
    input wire logic                        clk_i,
    input wire logic                        nrst_i,
    input wire logic                        ce_i,
    input wire logic [GROUPS*WIDTH-1:0]     cmd_i,
    input wire logic                        report_ack_i,
    // observed outputs
    input wire logic                        report_valid_o,
    input wire port_alarm_pkg::alarm_code_t report_code_o,
    input wire logic                        link_suspend_o,
    input wire logic [GROUPS*WIDTH-1:0]     drive_o,
    input wire logic [GROUPS-1:0]           fault_lamp_o,
    input wire logic                        alarm_lamp_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // offer still waiting, and offer taken by the host
    sequence s_offer; report_valid_o && !report_ack_i; endsequence
    sequence s_taken; report_valid_o && report_ack_i; endsequence
    a_lamp_is_suspend: assert property (alarm_lamp_o == link_suspend_o)
        else $error("alarm lamp differs from link suspend");
    a_offer_suspends: assert property (report_valid_o |-> link_suspend_o)
        else $error("code offered outside alarm state");
    a_code_low_pair: assert property (report_valid_o |-> report_code_o.code0[1:0] == 2'b11)
        else $error("first code byte low bits wrong");
    a_code_bit_six: assert property (report_valid_o |-> report_code_o.code1[6])
        else $error("second code byte bit six clear");
    a_code_group: assert property (report_valid_o |-> report_code_o.code1[4:0] inside {[1:GROUPS]})
        else $error("group field out of range");
    a_offer_holds: assert property (s_offer |=> report_valid_o && $stable(report_code_o))
        else $error("offer dropped before ack");
    a_taken_drops: assert property (s_taken |=> !report_valid_o)
        else $error("offer kept after ack");
    a_drive_needs_cmd: assert property ($past(ce_i) |-> (drive_o & ~$past(cmd_i)) == '0)
        else $error("output driven without command");
    // the lamp lights only after the whole group is already blanked
    for (genvar g = 0; g < GROUPS; g++) begin : gl
        a_heat_blanks: assert property ($rose(fault_lamp_o[g]) |-> drive_o[g*WIDTH +: WIDTH] == '0)
            else $error("hot group still driving");
    end
endmodule : port_alarm_sva
bind protected_output_port_alarm port_alarm_sva #(.GROUPS(GROUPS), .WIDTH(WIDTH),
    .RETRY_CYC(RETRY_CYC)) u_sva (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .cmd_i(cmd_i),
    .report_ack_i(report_ack_i), .report_valid_o(report_valid_o), .report_code_o(report_code_o),
    .link_suspend_o(link_suspend_o), .drive_o(drive_o), .fault_lamp_o(fault_lamp_o),
    .alarm_lamp_o(alarm_lamp_o));
`default_nettype wire

// File: sim/port_load_model.sv
`timescale 1ns/1ps
`default_nettype none
// lamp loads with optional shorts, plus the host taking alarm codes
module port_load_model (
    input  wire logic        clk_i,
    input  wire logic [63:0] drive_i,
    input  wire logic [63:0] short_i,
    input  wire logic        valid_i,
    input  wire logic [3:0]  ack_wait_i,
    output logic      [63:0] ovc_o,
    output logic             ack_o
);
    // no initialisers: ack_o and wait_r get one driver, the clocked process below;
    // the design holds its offer low in reset, so both settle at the first edge
    logic [3:0] wait_r;  // cycles the offer has stood
    // a shorted load draws excess current only while it is driven
    assign ovc_o = drive_i & short_i;
    // host answers one pulse after a chosen pause, never early
    always_ff @(posedge clk_i) begin
        wait_r <= valid_i ? wait_r + 4'h1 : 4'h0;
        ack_o  <= valid_i && !ack_o && (wait_r == ack_wait_i);
    end
endmodule : port_load_model
`default_nettype wire

// File: sim/protected_output_port_alarm_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module protected_output_port_alarm_tb_top;
    logic clk_i, nrst_i, ce_i, jmp, ack, valid, susp, alarm, prev;
    logic [63:0] cmd_i, ovc, drive, short_m;
    logic [7:0]  hot, cool, lamp;
    logic [3:0]  ack_wait;
    port_alarm_pkg::alarm_code_t code;
    int err_count, tests_run, n;
    ////////////////////////////////////////
    always #2.5 clk_i = ~clk_i;
    protected_output_port_alarm #(.RETRY_CYC(4)) DUT (.clk_i(clk_i), .nrst_i(nrst_i),
        .ce_i(ce_i), .cmd_i(cmd_i), .ovc_i(ovc), .hot_i(hot), .cool_i(cool),
        .alarm_report_jumper_i(jmp), .report_ack_i(ack), .report_valid_o(valid),
        .report_code_o(code), .link_suspend_o(susp), .drive_o(drive),
        .fault_lamp_o(lamp), .alarm_lamp_o(alarm));
    port_load_model u_far (.clk_i(clk_i), .drive_i(drive), .short_i(short_m),
        .valid_i(valid), .ack_wait_i(ack_wait), .ovc_o(ovc), .ack_o(ack));
    // one comparison, counted, with a line on mismatch
    task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(negedge clk_i);
    endtask : cyc
    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    // bounded wait for the alarm offer
    task automatic wait_valid;
        int k;
        for (k = 0; k < 50 && valid !== 1'b1; k++) cyc(1);
        if (k == 50) begin
            err_count++;
            summarize();
        end
    endtask : wait_valid
    ////////////////////////////////////////
    initial begin
        clk_i = 0; nrst_i = 0; ce_i = 1; cmd_i = '0; hot = '0; cool = '0;
        jmp = 1; short_m = '0; ack_wait = 4'h3; err_count = 0; tests_run = 0;
        cyc(8);
        chk("reset drive", 64'h0, drive);
        nrst_i = 1;
        cyc(4);
        cmd_i = 64'hF0F0_1234_5678_9ABC;
        cyc(2);
        chk("follow", cmd_i, drive);
        $display("test pass_through done");
        // a hard short on one output: only it cycles off and on
        short_m = 64'h0000_0000_0000_0008;
        n = 0;
        prev = drive[3];
        repeat (40) begin
            cyc(1);
            if (drive[3] !== prev) n++;
            prev = drive[3];
            chk("neighbours", cmd_i & ~short_m, drive & ~short_m);
        end
        chk("retry toggles", 64'h1, 64'(n >= 4));
        short_m = '0;
        cyc(20);
        chk("recovered", cmd_i, drive);
        $display("test overcurrent done");
        // overheat on group 2 with reporting on
        hot[2] = 1;
        cyc(4);
        hot[2] = 0;
        wait_valid();
        cyc(1);
        chk("code", 64'h4303, 64'(code));
        chk("lamp", 64'h04, 64'(lamp));
        chk("group hold", cmd_i & ~64'hFF_0000, drive);
        cyc(10);
        chk("taken", 64'h0, 64'(valid));
        chk("suspend", 64'h1, 64'(alarm));
        // an off command before cool is sensed must not release
        cmd_i[23:16] = 8'h00;
        cyc(4);
        cmd_i[23:16] = 8'h78;
        cyc(4);
        chk("no cool", cmd_i & ~64'hFF_0000, drive);
        cool[2] = 1;
        cmd_i[23:16] = 8'h00;
        cyc(4);
        cmd_i[23:16] = 8'h78;
        cyc(6);
        chk("released", cmd_i, drive);
        chk("lamp off", 64'h0, 64'({lamp, susp}));
        cool[2] = 0;
        $display("test overheat_report done");
        // reporting off: lamp lights but nothing goes to the host
        jmp = 0;
        cyc(3);
        hot[7] = 1;
        cyc(6);
        hot[7] = 0;
        cyc(4);
        chk("quiet lamp", 64'h80, 64'(lamp));
        chk("no report", 64'h0, 64'({valid, alarm}));
        nrst_i = 0;
        cyc(2);
        nrst_i = 1;
        cyc(4);
        chk("power cycle", cmd_i, drive);
        chk("lamps clear", 64'h0, 64'(lamp));
        $display("test jumper_power done");
        summarize();
    end
endmodule : protected_output_port_alarm_tb_top
`default_nettype wire
